// file: include/drp_defs.svh
// register indices, field positions, reset values and decode figures of the loop configuration block
// assumes inclusion by bare name from every file that needs it
`ifndef DRP_DEFS_SVH
`define DRP_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define DRP_IDX_BASE_HI 8'h28
`define DRP_IDX_BASE_LO 8'h29
`define DRP_IDX_MULT_HI 8'h2A
`define DRP_IDX_MULT_LO 8'h2B
`define DRP_IDX_NUM_HI 8'h2C
`define DRP_IDX_NUM_LO 8'h2D
`define DRP_IDX_DEN_HI 8'h2E
`define DRP_IDX_DEN_LO 8'h2F
`define DRP_IDX_CTRL 8'h30
`define DRP_IDX_RANK_HI 8'h31
`define DRP_IDX_RANK_LO 8'h32
`define DRP_IDX_OPSEL 8'h33
`define DRP_IDX_STATUS 8'h3C

// reset values
`define DRP_RST_BASE 16'h9C40
`define DRP_RST_MULT 16'h01E6
`define DRP_RST_RATIO 32'h00010001
`define DRP_RST_CTRL 8'h0D
`define DRP_RST_RANK_HI 8'h32
`define DRP_RST_RANK_LO 8'h10
`define DRP_RST_OPSEL 8'h03

// loop control field positions
`define DRP_CTRL_CAP_LSB 0
`define DRP_CTRL_SLOPE_LSB 2
`define DRP_CTRL_ALIGN_BIT 4
`define DRP_CTRL_BW_LSB 5

// rank fields: low one in bits 2:0, high one in bits 6:4
`define DRP_RANK_A_LSB 0
`define DRP_RANK_B_LSB 4
`define DRP_RANK_OFF 3'h7

// operating select field positions and mode codes
`define DRP_OPSEL_FB_BIT 5
`define DRP_OPSEL_REF_LSB 6
`define DRP_MODE_FREERUN 2'h0
`define DRP_MODE_HOLDOVER 2'h1
`define DRP_MODE_FORCED 2'h2
`define DRP_MODE_AUTO 2'h3

// supported base rate span in hertz
`define DRP_BASE_MIN 16'h03E8
`define DRP_BASE_MAX 16'h9C40

// capture range in ppm, zero meaning unlimited
`define DRP_CAP_PPM0 16'h0034
`define DRP_CAP_PPM1 16'h0082
`define DRP_CAP_PPM2 16'h0190
// phase slope limit in ns per second, zero meaning unlimited
`define DRP_SLOPE_NS0 20'h0EE48
`define DRP_SLOPE_NS1 20'h01D4C
`define DRP_SLOPE_NS2 20'h00375
// narrowest loop bandwidth in hertz, doubled per code step
`define DRP_BW_BASE_HZ 10'h00E
`define DRP_BW_RESERVED 3'h7

`endif

// file: include/drp_pkg.sv
// types shared by the loop configuration block and its reference selector
// assumes drp_defs.svh is reachable on the include path
package drp_pkg;

  typedef logic [1:0] drp_mode_t;
  typedef logic [2:0] drp_rank_t;

  // selector configuration carried from the register file
  typedef struct packed {
    drp_mode_t mode;
    logic [1:0] forced_ref;
    drp_rank_t [3:0] rank;
  } drp_sel_cfg_s;

  // selector state reported back
  typedef struct packed {
    logic [1:0] active_ref;
    logic locked;
    logic holdover;
    logic freerun;
  } drp_sel_stat_s;

  typedef enum logic [1:0] {
    DRP_ST_FREERUN,
    DRP_ST_LOCKED,
    DRP_ST_HOLDOVER
  } drp_loop_e;

  // full state of the register file and the frequency divider
  typedef struct packed {
    logic [15:0] base_rate;
    logic [15:0] rate_multiplier;
    logic [15:0] fec_numerator;
    logic [15:0] fec_denominator;
    logic [7:0] loop_ctrl;
    logic [7:0] rank_hi;
    logic [7:0] rank_lo;
    logic ext_fb;
    drp_mode_t mode;
    logic [1:0] forced_ref;
    logic [7:0] prdata;
    logic div_start;
    logic div_busy;
    logic [5:0] div_cnt;
    logic [47:0] div_quo;
    logic [16:0] div_rem;
    logic [47:0] nominal_freq;
  } drp_regs_s;

endpackage

// file: src/drp_ref_select.sv
// automatic and forced reference selection for the first digital loop
// assumes reference availability inputs are synchronous to mclk_i
`timescale 1ns/100ps
`include "drp_defs.svh"

module drp_ref_select
  import drp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire drp_sel_cfg_s cfg_i,
  input wire logic [3:0] ref_avail_i,
  output drp_sel_stat_s stat_o
);

  typedef struct packed {
    drp_loop_e st;
    logic [1:0] cur;
  } drp_sel_state_s;

  drp_sel_state_s s_r;
  drp_sel_state_s s_nxt;

  // next state: freerun, holdover, forced lock, forced holdover or automatic choice
  always_comb begin
    logic [3:0] cand;
    drp_rank_t best;
    logic any;
    logic [1:0] pick;
    logic pick_done;
    cand = 4'h0;
    best = `DRP_RANK_OFF;
    any = 1'b0;
    pick = 2'h0;
    pick_done = 1'b0;
    s_nxt = s_r;
    for (int i = 0; i < 4; i++) begin
      cand[i] = ref_avail_i[i] && (cfg_i.rank[i] != `DRP_RANK_OFF);
      if (cand[i] && (cfg_i.rank[i] < best)) begin
        best = cfg_i.rank[i];
      end
      any = any | cand[i];
    end
    for (int i = 0; i < 4; i++) begin
      if (!pick_done && cand[i] && (cfg_i.rank[i] == best)) begin
        pick = 2'(i);
        pick_done = 1'b1;
      end
    end
    unique case (cfg_i.mode)
      `DRP_MODE_FREERUN: begin
        s_nxt.st = DRP_ST_FREERUN;
      end
      `DRP_MODE_HOLDOVER: begin
        s_nxt.st = DRP_ST_HOLDOVER;
      end
      `DRP_MODE_FORCED: begin
        s_nxt.cur = cfg_i.forced_ref;
        s_nxt.st = ref_avail_i[cfg_i.forced_ref] ? DRP_ST_LOCKED : DRP_ST_HOLDOVER;
      end
      `DRP_MODE_AUTO: begin
        if (!any) begin
          s_nxt.st = DRP_ST_HOLDOVER;
        end else if (s_r.st == DRP_ST_LOCKED && cand[s_r.cur] && cfg_i.rank[s_r.cur] == best) begin
          s_nxt.st = DRP_ST_LOCKED;
        end else begin
          s_nxt.st = DRP_ST_LOCKED;
          s_nxt.cur = pick;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      s_r <= '{st: DRP_ST_FREERUN, cur: 2'h0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // status decode
  assign stat_o.active_ref = s_r.cur;
  assign stat_o.locked = (s_r.st == DRP_ST_LOCKED);
  assign stat_o.holdover = (s_r.st == DRP_ST_HOLDOVER);
  assign stat_o.freerun = (s_r.st == DRP_ST_FREERUN);

endmodule

// file: src/drp_loop_cfg.sv
// Contract
// - multi-byte registers map most significant byte first
// - base rate in hertz, 1 to 40 kHz
// - multiplier times base rate gives frequency
// - nominal frequency is base times multiplier times ratio
// - capture range select decodes four ppm spans
// - slope limit select decodes four slope limits
// - bit four requests output phase alignment
// - bandwidth code doubles from 14 Hz; 111 reserved
// - three-bit rank per reference, 111 disables it
// - lower rank number wins revertively when available
// - equal ranks switch non-revertively
// - mode field picks freerun, holdover, forced, automatic
// - automatic mode holds over only with none available
//
// byte-wide register file, nominal frequency divider and loop settings for one channel
// assumes an APB master on mclk_i and reference availability inputs synchronous to it
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "drp_defs.svh"

module drp_loop_cfg
  import drp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [3:0] ref_avail_i,
  output logic [15:0] base_rate_o,
  output logic [15:0] rate_multiplier_o,
  output logic [15:0] fec_numerator_o,
  output logic [15:0] fec_denominator_o,
  output logic [47:0] nominal_freq_o,
  output logic nominal_valid_o,
  output logic base_rate_unsupported_o,
  output logic [1:0] capture_range_select_o,
  output logic [15:0] capture_range_ppm_o,
  output logic [1:0] slope_limit_select_o,
  output logic [19:0] slope_limit_ns_o,
  output logic phase_align_request_o,
  output logic [2:0] bandwidth_select_o,
  output logic [9:0] bandwidth_hz_o,
  output logic bandwidth_reserved_o,
  output logic ext_feedback_enable_o,
  output logic [1:0] active_ref_o,
  output logic locked_o,
  output logic holdover_o,
  output logic freerun_o
);

  // the index field must fit the address bus
  if (ADDR_W < 10) begin : g_addr_chk
    $error("ADDR_W must be at least 10");
  end

  drp_regs_s r_r;
  drp_regs_s r_nxt;
  drp_sel_cfg_s sel_cfg;
  drp_sel_stat_s sel_stat;

  logic [7:0] idx;
  logic addr_ok;
  logic acc;
  logic wr;
  logic [7:0] wbyte;
  logic base_bad;

  // capture range in ppm for a select code
  function automatic logic [15:0] cap_ppm(input logic [1:0] code);
    unique case (code)
      2'h0: cap_ppm = `DRP_CAP_PPM0;
      2'h1: cap_ppm = `DRP_CAP_PPM1;
      2'h2: cap_ppm = `DRP_CAP_PPM2;
      2'h3: cap_ppm = 16'h0000;
    endcase
  endfunction

  // slope limit in ns per second for a select code
  function automatic logic [19:0] slope_ns(input logic [1:0] code);
    unique case (code)
      2'h0: slope_ns = `DRP_SLOPE_NS0;
      2'h1: slope_ns = `DRP_SLOPE_NS1;
      2'h2: slope_ns = `DRP_SLOPE_NS2;
      2'h3: slope_ns = 20'h00000;
    endcase
  endfunction

  // register index is mapped when listed; word alignment is checked in the bus decode
  function automatic logic idx_mapped(input logic [7:0] i);
    idx_mapped = ((i >= `DRP_IDX_BASE_HI) && (i <= `DRP_IDX_OPSEL)) || (i == `DRP_IDX_STATUS);
  endfunction

  // bus decode
  assign idx = paddr_i[9:2];
  assign addr_ok = (paddr_i[1:0] == 2'h0) && ((paddr_i >> 10) == '0) && idx_mapped(idx);
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i && addr_ok;
  assign wbyte = pwdata_i[7:0];
  assign base_bad = (r_r.base_rate < `DRP_BASE_MIN) || (r_r.base_rate > `DRP_BASE_MAX);

  // selector configuration from the rank and operating select registers
  assign sel_cfg.mode = r_r.mode;
  assign sel_cfg.forced_ref = r_r.forced_ref;
  assign sel_cfg.rank[0] = r_r.rank_lo[`DRP_RANK_A_LSB +: 3];
  assign sel_cfg.rank[1] = r_r.rank_lo[`DRP_RANK_B_LSB +: 3];
  assign sel_cfg.rank[2] = r_r.rank_hi[`DRP_RANK_A_LSB +: 3];
  assign sel_cfg.rank[3] = r_r.rank_hi[`DRP_RANK_B_LSB +: 3];

  drp_ref_select u_sel (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .cfg_i(sel_cfg),
    .ref_avail_i(ref_avail_i),
    .stat_o(sel_stat)
  );

  // register writes, read data capture and the nominal frequency divider
  always_comb begin
    logic [7:0] rd;
    logic [16:0] shifted;
    logic cfg_wr;
    rd = 8'h00;
    shifted = 17'h00000;
    cfg_wr = 1'b0;
    r_nxt = r_r;
    // writes take effect at the access edge; most significant byte at lower index
    if (wr) begin
      unique case (idx)
        `DRP_IDX_BASE_HI: r_nxt.base_rate[15:8] = wbyte;
        `DRP_IDX_BASE_LO: r_nxt.base_rate[7:0] = wbyte;
        `DRP_IDX_MULT_HI: r_nxt.rate_multiplier[15:8] = wbyte;
        `DRP_IDX_MULT_LO: r_nxt.rate_multiplier[7:0] = wbyte;
        `DRP_IDX_NUM_HI: r_nxt.fec_numerator[15:8] = wbyte;
        `DRP_IDX_NUM_LO: r_nxt.fec_numerator[7:0] = wbyte;
        `DRP_IDX_DEN_HI: r_nxt.fec_denominator[15:8] = wbyte;
        `DRP_IDX_DEN_LO: r_nxt.fec_denominator[7:0] = wbyte;
        `DRP_IDX_CTRL: r_nxt.loop_ctrl = wbyte;
        `DRP_IDX_RANK_HI: r_nxt.rank_hi = wbyte & 8'h77;
        `DRP_IDX_RANK_LO: r_nxt.rank_lo = wbyte & 8'h77;
        `DRP_IDX_OPSEL: begin
          r_nxt.mode = wbyte[1:0];
          r_nxt.ext_fb = wbyte[`DRP_OPSEL_FB_BIT];
          r_nxt.forced_ref = wbyte[`DRP_OPSEL_REF_LSB +: 2];
        end
        default: r_nxt.prdata = r_nxt.prdata; // status is read-only
      endcase
      cfg_wr = (idx <= `DRP_IDX_DEN_LO);
    end
    // read data is captured in the setup cycle and held through the access
    unique case (idx)
      `DRP_IDX_BASE_HI: rd = r_r.base_rate[15:8];
      `DRP_IDX_BASE_LO: rd = r_r.base_rate[7:0];
      `DRP_IDX_MULT_HI: rd = r_r.rate_multiplier[15:8];
      `DRP_IDX_MULT_LO: rd = r_r.rate_multiplier[7:0];
      `DRP_IDX_NUM_HI: rd = r_r.fec_numerator[15:8];
      `DRP_IDX_NUM_LO: rd = r_r.fec_numerator[7:0];
      `DRP_IDX_DEN_HI: rd = r_r.fec_denominator[15:8];
      `DRP_IDX_DEN_LO: rd = r_r.fec_denominator[7:0];
      `DRP_IDX_CTRL: rd = r_r.loop_ctrl;
      `DRP_IDX_RANK_HI: rd = r_r.rank_hi;
      `DRP_IDX_RANK_LO: rd = r_r.rank_lo;
      `DRP_IDX_OPSEL: begin
        // in automatic mode the reference field shows the chosen input
        rd = {((r_r.mode == `DRP_MODE_AUTO) ? sel_stat.active_ref : r_r.forced_ref),
              r_r.ext_fb, 3'h0, r_r.mode};
      end
      `DRP_IDX_STATUS: begin
        rd = {r_r.div_busy, base_bad, sel_stat.active_ref, 1'b0,
              sel_stat.locked, sel_stat.freerun, sel_stat.holdover};
      end
      default: rd = 8'h00;
    endcase
    if (psel_i && !penable_i) begin
      r_nxt.prdata = (addr_ok && !pwrite_i) ? rd : 8'h00;
    end
    // divider: base times multiplier times numerator over denominator
    if (r_r.div_start) begin
      r_nxt.div_start = 1'b0;
      r_nxt.div_busy = 1'b1;
      r_nxt.div_cnt = 6'h00;
      r_nxt.div_rem = 17'h00000;
      r_nxt.div_quo = 48'(r_r.base_rate) * 48'(r_r.rate_multiplier) * 48'(r_r.fec_numerator);
    end else if (r_r.div_busy) begin
      shifted = {r_r.div_rem[15:0], r_r.div_quo[47]};
      if (shifted >= {1'b0, r_r.fec_denominator}) begin
        r_nxt.div_rem = shifted - {1'b0, r_r.fec_denominator};
        r_nxt.div_quo = {r_r.div_quo[46:0], 1'b1};
      end else begin
        r_nxt.div_rem = shifted;
        r_nxt.div_quo = {r_r.div_quo[46:0], 1'b0};
      end
      r_nxt.div_cnt = r_r.div_cnt + 6'h01;
      if (r_r.div_cnt == 6'h2F) begin
        r_nxt.div_busy = 1'b0;
        // a zero denominator saturates instead of giving a quotient
        r_nxt.nominal_freq = (r_r.fec_denominator == 16'h0000) ? '1 : {r_nxt.div_quo};
      end
    end
    // a write to a descriptor register restarts the division with the fresh descriptors
    if (cfg_wr) begin
      r_nxt.div_start = 1'b1;
      r_nxt.div_busy = 1'b0;
    end
  end

  // state register with documented defaults
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      r_r.base_rate <= `DRP_RST_BASE;
      r_r.rate_multiplier <= `DRP_RST_MULT;
      r_r.fec_numerator <= 16'(`DRP_RST_RATIO >> 16);
      r_r.fec_denominator <= 16'(`DRP_RST_RATIO);
      r_r.loop_ctrl <= `DRP_RST_CTRL;
      r_r.rank_hi <= `DRP_RST_RANK_HI;
      r_r.rank_lo <= `DRP_RST_RANK_LO;
      r_r.ext_fb <= 1'b0;
      r_r.mode <= 2'(`DRP_RST_OPSEL);
      r_r.forced_ref <= 2'h0;
      r_r.prdata <= 8'h00;
      r_r.div_start <= 1'b1; // computes the default nominal frequency
      r_r.div_busy <= 1'b0;
      r_r.div_cnt <= 6'h00;
      r_r.div_quo <= 48'h000000000000;
      r_r.div_rem <= 17'h00000;
      r_r.nominal_freq <= 48'h000000000000;
    end else begin
      r_r <= r_nxt;
    end
  end

  // bus answer: no wait states, error on unmapped addresses
  assign prdata_o = {24'h000000, r_r.prdata};
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !addr_ok;

  // descriptor outputs
  assign base_rate_o = r_r.base_rate;
  assign rate_multiplier_o = r_r.rate_multiplier;
  assign fec_numerator_o = r_r.fec_numerator;
  assign fec_denominator_o = r_r.fec_denominator;
  assign nominal_freq_o = r_r.nominal_freq;
  assign nominal_valid_o = !r_r.div_busy && !r_r.div_start;
  assign base_rate_unsupported_o = base_bad;

  // loop control decode
  assign capture_range_select_o = r_r.loop_ctrl[`DRP_CTRL_CAP_LSB +: 2];
  assign capture_range_ppm_o = cap_ppm(r_r.loop_ctrl[`DRP_CTRL_CAP_LSB +: 2]);
  assign slope_limit_select_o = r_r.loop_ctrl[`DRP_CTRL_SLOPE_LSB +: 2];
  assign slope_limit_ns_o = slope_ns(r_r.loop_ctrl[`DRP_CTRL_SLOPE_LSB +: 2]);
  assign phase_align_request_o = r_r.loop_ctrl[`DRP_CTRL_ALIGN_BIT];
  assign bandwidth_select_o = r_r.loop_ctrl[`DRP_CTRL_BW_LSB +: 3];
  assign bandwidth_reserved_o = (r_r.loop_ctrl[`DRP_CTRL_BW_LSB +: 3] == `DRP_BW_RESERVED);
  assign bandwidth_hz_o = bandwidth_reserved_o ? 10'h000 : (`DRP_BW_BASE_HZ << r_r.loop_ctrl[`DRP_CTRL_BW_LSB +: 3]);
  assign ext_feedback_enable_o = r_r.ext_fb;

  // selector state
  assign active_ref_o = sel_stat.active_ref;
  assign locked_o = sel_stat.locked;
  assign holdover_o = sel_stat.holdover;
  assign freerun_o = sel_stat.freerun;

endmodule

// file: verif/drp_loop_cfg_assertions.sv
// port-level checks of the loop configuration block
// assumes a bind onto drp_loop_cfg that hands on ADDR_W
`timescale 1ns/100ps
`include "drp_defs.svh"
module drp_loop_cfg_assertions
  import drp_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] ref_avail_i,
  input wire logic [15:0] base_rate_o,
  input wire logic [15:0] rate_multiplier_o,
  input wire logic [15:0] fec_numerator_o,
  input wire logic [15:0] fec_denominator_o,
  input wire logic [47:0] nominal_freq_o,
  input wire logic nominal_valid_o,
  input wire logic base_rate_unsupported_o,
  input wire logic [1:0] capture_range_select_o,
  input wire logic [15:0] capture_range_ppm_o,
  input wire logic [1:0] slope_limit_select_o,
  input wire logic [19:0] slope_limit_ns_o,
  input wire logic phase_align_request_o,
  input wire logic [2:0] bandwidth_select_o,
  input wire logic [9:0] bandwidth_hz_o,
  input wire logic bandwidth_reserved_o,
  input wire logic ext_feedback_enable_o,
  input wire logic [1:0] active_ref_o,
  input wire logic locked_o,
  input wire logic holdover_o,
  input wire logic freerun_o
);
  logic [3:0] avail_r;
  logic [63:0] nom_calc;
  logic wr_en;
  // write strobe and the expected quotient of the nominal rate
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign nom_calc = (fec_denominator_o == 16'h0000) ? {64{1'b1}} :
    64'(base_rate_o) * rate_multiplier_o * fec_numerator_o / fec_denominator_o;
  // availability as the selector saw it one edge ago
  always_ff @(posedge mclk_i) begin
    avail_r <= ref_avail_i;
  end
  default clocking dc @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  chk_reset_defaults: assert property (disable iff (1'b0)
    $rose(rstn_i) |-> {base_rate_o, rate_multiplier_o, fec_numerator_o, fec_denominator_o} ==
    {`DRP_RST_BASE, `DRP_RST_MULT, `DRP_RST_RATIO} && capture_range_select_o == 2'h1 &&
    slope_limit_select_o == 2'h3 && !phase_align_request_o && bandwidth_select_o == 3'h0 && freerun_o)
    else $error("register defaults wrong after reset");
  chk_msb_first: assert property (wr_en && paddr_i == ADDR_W'({`DRP_IDX_BASE_HI, 2'b00}) |=>
    base_rate_o == {$past(pwdata_i[7:0]), $past(base_rate_o[7:0])}) else $error("base rate high byte wrong");
  chk_base_range: assert property (base_rate_unsupported_o ==
    (base_rate_o < 16'h03E8 || base_rate_o > 16'h9C40)) else $error("base rate range flag wrong");
  chk_nominal_value: assert property ($rose(nominal_valid_o) |->
    nominal_freq_o == nom_calc[47:0]) else $error("nominal frequency wrong");
  chk_capture_decode: assert property (capture_range_ppm_o == (capture_range_select_o == 2'h0 ? 16'h0034 :
    capture_range_select_o == 2'h1 ? 16'h0082 : capture_range_select_o == 2'h2 ? 16'h0190 : 16'h0000))
    else $error("capture range decode wrong");
  chk_slope_decode: assert property (slope_limit_ns_o == (slope_limit_select_o == 2'h0 ? 20'h0EE48 :
    slope_limit_select_o == 2'h1 ? 20'h01D4C : slope_limit_select_o == 2'h2 ? 20'h00375 : 20'h00000))
    else $error("slope limit decode wrong");
  chk_align_write: assert property (wr_en && paddr_i == ADDR_W'({`DRP_IDX_CTRL, 2'b00}) |=>
    phase_align_request_o == $past(pwdata_i[4])) else $error("phase align bit wrong");
  chk_fb_write: assert property (wr_en && paddr_i == ADDR_W'({`DRP_IDX_OPSEL, 2'b00}) |=>
    ext_feedback_enable_o == $past(pwdata_i[5])) else $error("feedback enable bit wrong");
  chk_bw_decode: assert property (bandwidth_reserved_o == (bandwidth_select_o == 3'h7) &&
    bandwidth_hz_o == (bandwidth_reserved_o ? 10'h000 : 10'(10'h00E << bandwidth_select_o)))
    else $error("bandwidth decode wrong");
  chk_one_state: assert property ($onehot({locked_o, holdover_o, freerun_o}))
    else $error("loop state flags not exclusive");
  chk_lock_avail: assert property (locked_o |-> avail_r[active_ref_o])
    else $error("locked to an unavailable reference");
  cov_lock_two: cover property (locked_o && active_ref_o == 2'h2);
  cov_holdover: cover property ($rose(holdover_o));
  cov_bw_reserved: cover property (bandwidth_reserved_o);
endmodule

// file: verif/drp_ref_model.sv
// availability of the four reference inputs, as seen by the loop
// assumes the bench calls apply from its own process
`timescale 1ns/100ps
module drp_ref_model (
  input wire logic mclk_i,
  output logic [3:0] avail_o
);
  initial avail_o = 4'h0;
  // new availability lands just after an edge, promptly or some edges late
  task automatic apply(input logic [3:0] mask, input int lag);
    repeat (lag + 1) @(posedge mclk_i);
    avail_o <= mask;
  endtask
endmodule

// file: verif/drp_loop_cfg_bench.sv
// self-checking bench for the loop configuration block
// assumes drp_pkg compiled first and drp_defs.svh on the include path
`timescale 1ns/100ps
module drp_loop_cfg_bench;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, nominal_valid_o, base_rate_unsupported_o, phase_align_request_o;
  logic bandwidth_reserved_o, ext_feedback_enable_o, locked_o, holdover_o, freerun_o;
  logic [3:0] ref_avail_i;
  logic [15:0] base_rate_o, rate_multiplier_o, fec_numerator_o, fec_denominator_o, capture_range_ppm_o;
  logic [47:0] nominal_freq_o, obs;
  logic [1:0] capture_range_select_o, slope_limit_select_o, active_ref_o;
  logic [19:0] slope_limit_ns_o;
  logic [2:0] bandwidth_select_o;
  logic [9:0] bandwidth_hz_o;
  logic [31:0] seed = 32'h65CB92FA;
  logic [47:0] note_q[$];
  int kind_q[$];
  int failures = 0, total_checks = 0;
  event smp;
  string nm[5] = '{"read", "select", "nominal", "decode", "flags"};
  logic [7:0] dflt[12] = '{8'h9C, 8'h40, 8'h01, 8'hE6, 8'h00, 8'h01, 8'h00, 8'h01, 8'h0D, 8'h32, 8'h10, 8'h03};
  logic [7:0] fec[8] = '{8'h61, 8'hA8, 8'h18, 8'h6A, 8'h41, 8'hBE, 8'h3B, 8'h80};
  logic [7:0] plain[8] = '{8'h9C, 8'h40, 8'h0F, 8'h30, 8'h00, 8'h01, 8'h00, 8'h01};
  logic [3:0] av[10] = '{4'hF, 4'hD, 4'hC, 4'hD, 4'hF, 4'h8, 4'h8, 4'h0, 4'hF, 4'hF};
  logic [7:0] op[10] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'hC2, 8'hC2, 8'h01, 8'h00};
  int kd[10] = '{1, 1, 1, 1, 1, 4, 1, 4, 4, 4};
  logic [47:0] ex[10] = '{48'h0C, 48'h04, 48'h14, 48'h14, 48'h0C, 48'h2, 48'h1C, 48'h2, 48'h2, 48'h1};

  drp_loop_cfg #(.ADDR_W(12)) drp_loop_cfg_inst (.*);
  drp_ref_model drp_ref_model_inst (.mclk_i(mclk_i), .avail_o(ref_avail_i));

  // 200 MHz clock
  always #2.5 mclk_i = ~mclk_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [47:0] nom(input logic [15:0] b, k, m, n);
    return 48'((64'(b) * k * m) / n);
  endfunction

  // expected {ppm, ns, hz, reserved, align} for a loop control byte
  function automatic logic [47:0] dec(input logic [7:0] c);
    logic [15:0] ppm;
    logic [19:0] ns;
    ppm = c[1:0] == 2'h0 ? 16'h0034 : c[1:0] == 2'h1 ? 16'h0082 : c[1:0] == 2'h2 ? 16'h0190 : 16'h0000;
    ns = c[3:2] == 2'h0 ? 20'h0EE48 : c[3:2] == 2'h1 ? 20'h01D4C : c[3:2] == 2'h2 ? 20'h00375 : 20'h00000;
    return {ppm, ns, c[7:5] == 3'h7 ? 10'h000 : 10'(10'h00E << c[7:5]), c[7:5] == 3'h7, c[4]};
  endfunction

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic note(input int k, input logic [47:0] e);
    kind_q.push_back(k);
    note_q.push_back(e);
    -> smp;
  endtask

  // one APB transfer; a read notes its expected byte and error flag
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic er = 1'b0,
                     input logic [1:0] lo = 2'b00);
    int n;
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {2'b00, idx, lo};
    pwdata_i <= {24'h0, d};
    @(posedge mclk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      finish_test();
    end
    if (!w) note(0, {15'h0, er, 24'h0, d});
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    repeat (3) @(posedge mclk_i);
    while (nominal_valid_o !== 1'b1 && n < 300) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 300) begin
      failures++;
      finish_test();
    end
  endtask

  // compare every pending note, oldest first; two notes may land in one time step
  always @(smp) begin
    while (kind_q.size() > 0) begin
      case (kind_q[0])
        0: obs = {15'h0, pslverr_o, prdata_o};
        1: obs = 48'({active_ref_o, locked_o, holdover_o, freerun_o});
        2: obs = nominal_freq_o;
        3: obs = {capture_range_ppm_o, slope_limit_ns_o, bandwidth_hz_o, bandwidth_reserved_o, phase_align_request_o};
        default: obs = 48'({locked_o, holdover_o, freerun_o});
      endcase
      check(nm[kind_q[0]], obs, note_q[0]);
      void'(kind_q.pop_front());
      void'(note_q.pop_front());
    end
  end

  // main sequence
  initial begin
    logic [7:0] c;
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
    foreach (dflt[i]) apb(1'b0, 8'h28 + 8'(i), dflt[i]);
    wait_valid();
    note(2, nom(16'h9C40, 16'h01E6, 16'h0001, 16'h0001));
    apb(1'b0, 8'h3D, 8'h00, 1'b1);
    apb(1'b0, 8'h30, 8'h00, 1'b1, 2'h1);
    apb(1'b1, 8'h3D, 8'hFF);
    apb(1'b0, 8'h30, 8'h0D);
    foreach (fec[i]) apb(1'b1, 8'h28 + 8'(i), fec[i]);
    foreach (fec[i]) apb(1'b0, 8'h28 + 8'(i), fec[i]);
    wait_valid();
    note(2, nom(16'h61A8, 16'h186A, 16'h41BE, 16'h3B80));
    foreach (plain[i]) apb(1'b1, 8'h28 + 8'(i), plain[i]);
    wait_valid();
    note(2, nom(16'h9C40, 16'h0F30, 16'h0001, 16'h0001));
    for (int i = 0; i < 12; i++) begin
      c = (i < 8) ? {3'(i), 1'(i), 2'(i), 2'(i)} : 8'(rnd()) & 8'hEF;
      apb(1'b1, 8'h30, c);
      apb(1'b0, 8'h30, c);
      note(3, dec(c));
    end
    c = 8'(rnd());
    apb(1'b1, 8'h31, c);
    apb(1'b0, 8'h31, c & 8'h77);
    apb(1'b1, 8'h31, 8'h71);
    apb(1'b1, 8'h32, 8'h01);
    for (int i = 0; i < 10; i++) begin
      drp_ref_model_inst.apply(av[i], int'(rnd() & 32'h3));
      apb(1'b1, 8'h33, op[i]);
      repeat (2) @(posedge mclk_i);
      note(kd[i], ex[i]);
    end
    drp_ref_model_inst.apply(4'h2, 0);
    apb(1'b1, 8'h33, 8'h23);
    apb(1'b1, 8'h28, 8'h03);
    apb(1'b1, 8'h29, 8'hE7);
    wait_valid();
    apb(1'b0, 8'h33, 8'h63);
    apb(1'b0, 8'h3C, 8'h54);
    apb(1'b1, 8'h29, 8'hE8);
    wait_valid();
    apb(1'b0, 8'h3C, 8'h14);
    drp_ref_model_inst.apply(4'h0, 0);
    rstn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    foreach (dflt[i]) apb(1'b0, 8'h28 + 8'(i), dflt[i]);
    repeat (2) @(posedge mclk_i);
    finish_test();
  end

  // cut a hang short
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule

bind drp_loop_cfg drp_loop_cfg_assertions #(.ADDR_W(ADDR_W)) drp_loop_cfg_assertions_inst (.*);
